// file: rtl/ipr_pkg.sv
// Constants, carriers and helpers for the interrupt priority register bank.
// Assumes a single 10 MHz clock domain and a plain one-cycle register port.
package ipr_pkg;

	localparam int NUM_REGS    = 5;
	localparam int FLD_PER_REG = 4;
	localparam int SRC_NUM     = 20;
	localparam int FLD_W       = 3;
	localparam int FLD_STRIDE  = 4;
	localparam int DATA_W      = 16;
	localparam int ADDR_W      = 3;
	localparam int SRC_W       = 5;
	localparam int CLK_HZ      = 10000000;

	// Slot 3 sits in bits 14-12, slot 0 in bits 2-0
	localparam int SLOT_HI = 3;
	localparam int SLOT_MH = 2;
	localparam int SLOT_ML = 1;
	localparam int SLOT_LO = 0;

	typedef logic [FLD_W-1:0] ipr_prio_t;
	typedef logic [SRC_NUM-1:0][FLD_W-1:0] ipr_prio_vec_t;

	localparam ipr_prio_t PRIO_OFF   = 3'h0;
	localparam ipr_prio_t PRIO_MIN   = 3'h1;
	localparam ipr_prio_t PRIO_MAX   = 3'h7;
	localparam ipr_prio_t PRIO_RESET = 3'h4;

	localparam logic [DATA_W-1:0] IMPL_MASK  = 16'h7777;
	localparam logic [DATA_W-1:0] RESET_WORD = 16'h4444;

	localparam logic [ADDR_W-1:0] ADDR_CRYPTO_SPI    = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_CAPTURE_DMA   = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_COMPARE = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_PARPORT = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_I2C     = 3'h4;

	// Source index is register index times four plus slot
	localparam logic [SRC_W-1:0] SRC_SERIAL2_GENERAL     = 5'h00;
	localparam logic [SRC_W-1:0] SRC_SERIAL2_TRANSMIT    = 5'h01;
	localparam logic [SRC_W-1:0] SRC_CRYPTO_BUFFER_FREE  = 5'h02;
	localparam logic [SRC_W-1:0] SRC_CRYPTO_ROLLOVER     = 5'h03;
	localparam logic [SRC_W-1:0] SRC_DMA_CHANNEL3        = 5'h04;
	localparam logic [SRC_W-1:0] SRC_CAPTURE3            = 5'h05;
	localparam logic [SRC_W-1:0] SRC_CAPTURE4            = 5'h06;
	localparam logic [SRC_W-1:0] SRC_CAPTURE5            = 5'h07;
	localparam logic [SRC_W-1:0] SRC_CAPTURE6            = 5'h08;
	localparam logic [SRC_W-1:0] SRC_COMPARE5            = 5'h09;
	localparam logic [SRC_W-1:0] SRC_COMPARE6            = 5'h0a;
	localparam logic [SRC_W-1:0] SRC_CC_TIMER3           = 5'h0b;
	localparam logic [SRC_W-1:0] SRC_CC_TIMER4           = 5'h0c;
	localparam logic [SRC_W-1:0] SRC_PARALLEL_PORT       = 5'h0d;
	localparam logic [SRC_W-1:0] SRC_DMA_CHANNEL4        = 5'h0e;
	localparam logic [SRC_W-1:0] SRC_CC_TIMER5           = 5'h0f;
	localparam logic [SRC_W-1:0] SRC_CC_TIMER6           = 5'h10;
	localparam logic [SRC_W-1:0] SRC_I2C2_SLAVE_EVENT    = 5'h11;
	localparam logic [SRC_W-1:0] SRC_I2C2_MASTER_EVENT   = 5'h12;
	localparam logic [SRC_W-1:0] SRC_CC_TIMER7           = 5'h13;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ipr_bus_s;

	typedef struct packed {
		logic             valid;
		ipr_prio_t        level;
		logic [SRC_W-1:0] src;
	} ipr_grant_s;

	typedef struct packed {
		ipr_prio_vec_t       prio;
		logic [DATA_W-1:0]   rdata;
		ipr_grant_s          grant;
		logic [NUM_REGS-1:0] touched;
	} ipr_state_s;

	localparam ipr_state_s RST_STATE = '{
		prio:    {SRC_NUM{PRIO_RESET}},
		rdata:   '0,
		grant:   '0,
		touched: '0
	};

	function automatic int fld_lsb(input int slot);
		return slot * FLD_STRIDE;
	endfunction

	function automatic logic [SRC_W-1:0] src_index(input logic [ADDR_W-1:0] a, input int slot);
		return SRC_W'(int'(a) * FLD_PER_REG + slot);
	endfunction

endpackage

// file: rtl/ipr_arb.sv
// Priority arbiter: picks the pending, enabled source with the highest level.
// Assumes pending flags already combine flag and enable; purely combinational.
`timescale 1ns/1ns
`default_nettype none

module ipr_arb
(
	input  wire ipr_pkg::ipr_prio_vec_t          prio_i,
	input  wire logic [ipr_pkg::SRC_NUM-1:0]     pending_i,
	output ipr_pkg::ipr_grant_s                  grant_o
);

	// Strict compare: on equal levels the lower source index keeps the grant
	always_comb
	begin
		grant_o = '0;
		for (int i = 0; i < ipr_pkg::SRC_NUM; i++)
		begin
			if (pending_i[i] && prio_i[i] != ipr_pkg::PRIO_OFF
				&& prio_i[i] > grant_o.level)
			begin
				grant_o.valid = 1'b1;
				grant_o.level = prio_i[i];
				grant_o.src   = ipr_pkg::SRC_W'(i);
			end
		end
	end

endmodule

`default_nettype wire

// file: rtl/ipr_prio_regs.sv
// Five 16-bit interrupt priority registers with twenty 3-bit fields,
// a register port and the arbitration that the fields steer.
// Assumes one 10 MHz clock and pending flags from logic on that clock.
`timescale 1ns/1ns
`default_nettype none

module ipr_prio_regs
(
	input  wire logic                          clk_i,
	input  wire logic                          arst_n_i,
	input  wire ipr_pkg::ipr_bus_s             bus_i,
	input  wire logic [ipr_pkg::SRC_NUM-1:0]   pending_i,
	output logic [ipr_pkg::DATA_W-1:0]         rdata_o,
	output ipr_pkg::ipr_prio_vec_t             prio_o,
	output ipr_pkg::ipr_grant_s                grant_o
);

	ipr_pkg::ipr_state_s cur;
	ipr_pkg::ipr_state_s next_cur;
	ipr_pkg::ipr_grant_s arb_grant;
	logic                addr_ok;

	function automatic logic [ipr_pkg::DATA_W-1:0] read_word
	(
		input ipr_pkg::ipr_prio_vec_t          p,
		input logic [ipr_pkg::ADDR_W-1:0]      a
	);
		logic [ipr_pkg::DATA_W-1:0] w;
		w = '0;
		for (int s = 0; s < ipr_pkg::FLD_PER_REG; s++)
		begin
			w[ipr_pkg::fld_lsb(s) +: ipr_pkg::FLD_W] = p[ipr_pkg::src_index(a, s)];
		end
		return w;
	endfunction

	assign addr_ok = bus_i.addr < ipr_pkg::ADDR_W'(ipr_pkg::NUM_REGS);

	// Arbitration looks at the registered fields, never the bus data
	ipr_arb u_arb
	(
		.prio_i    (cur.prio),
		.pending_i (pending_i),
		.grant_o   (arb_grant)
	);

	always_comb
	begin
		next_cur = cur;
		// Read data live for exactly one cycle after the strobe
		next_cur.rdata = '0;
		if (bus_i.rd && addr_ok)
		begin
			next_cur.rdata = read_word(cur.prio, bus_i.addr);
		end
		// Unmapped writes fall through; reserved bits are never stored
		if (bus_i.wr && addr_ok)
		begin
			for (int s = 0; s < ipr_pkg::FLD_PER_REG; s++)
			begin
				next_cur.prio[ipr_pkg::src_index(bus_i.addr, s)] =
					bus_i.wdata[ipr_pkg::fld_lsb(s) +: ipr_pkg::FLD_W];
			end
			next_cur.touched[bus_i.addr] = 1'b1;
		end
		next_cur.grant = arb_grant;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cur <= ipr_pkg::RST_STATE;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	assign rdata_o = cur.rdata;
	assign prio_o  = cur.prio;
	assign grant_o = cur.grant;

	// Helper terms read only by the checks below
	logic any_enabled;
	logic any_top;
	logic only_min;
	logic any_higher;

	always_comb
	begin
		any_enabled = 1'b0;
		any_top     = 1'b0;
		only_min    = 1'b1;
		any_higher  = 1'b0;
		for (int i = 0; i < ipr_pkg::SRC_NUM; i++)
		begin
			if (pending_i[i] && cur.prio[i] != ipr_pkg::PRIO_OFF)
			begin
				any_enabled = 1'b1;
				if (cur.prio[i] == ipr_pkg::PRIO_MAX)
				begin
					any_top = 1'b1;
				end
				if (cur.prio[i] != ipr_pkg::PRIO_MIN)
				begin
					only_min = 1'b0;
				end
				if (cur.prio[i] > arb_grant.level)
				begin
					any_higher = 1'b1;
				end
			end
		end
		only_min = only_min && any_enabled;
	end

	default clocking cb @(posedge clk_i);
	endclocking

	default disable iff (!arst_n_i);

	a_rsv_read_zero:
	assert property (
		(rdata_o & ~ipr_pkg::IMPL_MASK) == '0
	)
	else $error("reserved bits read non-zero");

	a_read_window:
	assert property (
		!(bus_i.rd && addr_ok) |=> rdata_o == '0
	)
	else $error("read data outside the cycle after a read");

	a_write_readback:
	assert property (
		(bus_i.wr && addr_ok)
		##1 (bus_i.rd && !bus_i.wr && bus_i.addr == $past(bus_i.addr))
		|=> rdata_o == ($past(bus_i.wdata, 2) & ipr_pkg::IMPL_MASK)
	)
	else $error("read did not return the last written value");

	a_reset_word:
	assert property (
		(bus_i.rd && addr_ok && !cur.touched[bus_i.addr])
		|=> rdata_o == ipr_pkg::RESET_WORD
	)
	else $error("untouched register did not read the reset value");

	a_top_level:
	assert property (
		any_top |-> (arb_grant.valid && arb_grant.level == ipr_pkg::PRIO_MAX)
		##1 (grant_o.level == ipr_pkg::PRIO_MAX)
	)
	else $error("level 7 source not granted at level 7");

	a_min_level:
	assert property (
		only_min |-> arb_grant.valid && arb_grant.level == ipr_pkg::PRIO_MIN
	)
	else $error("level 1 source not serviced at level 1");

	a_off_silent:
	assert property (
		arb_grant.valid |-> pending_i[arb_grant.src]
			&& cur.prio[arb_grant.src] != ipr_pkg::PRIO_OFF
	)
	else $error("disabled or idle source was granted");

	a_none_enabled:
	assert property (
		!any_enabled |=> !grant_o.valid
	)
	else $error("grant with no enabled pending source");

	a_highest_first:
	assert property (
		arb_grant.valid |-> !any_higher
			&& arb_grant.level == cur.prio[arb_grant.src]
	)
	else $error("a higher pending level was passed over");

	a_write_steers:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_CAPTURE_DMA)
		|=> prio_o[ipr_pkg::SRC_CAPTURE5]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_HI) +: ipr_pkg::FLD_W])
	)
	else $error("written field not in effect next cycle");

	a_map_first:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_CRYPTO_SPI)
		|=> prio_o[ipr_pkg::SRC_SERIAL2_TRANSMIT]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_ML) +: ipr_pkg::FLD_W])
	)
	else $error("serial 2 transmit field misplaced");

	a_map_third:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_COMPARE)
		|=> prio_o[ipr_pkg::SRC_COMPARE6]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_MH) +: ipr_pkg::FLD_W])
	)
	else $error("compare 6 field misplaced");

	a_map_fourth:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_PARPORT)
		|=> prio_o[ipr_pkg::SRC_CC_TIMER4]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_LO) +: ipr_pkg::FLD_W])
	)
	else $error("timer 4 field misplaced");

	a_map_fifth:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_I2C)
		|=> prio_o[ipr_pkg::SRC_I2C2_MASTER_EVENT]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_MH) +: ipr_pkg::FLD_W])
	)
	else $error("I2C2 master field misplaced");

	a_map_second:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_CAPTURE_DMA)
		|=> prio_o[ipr_pkg::SRC_DMA_CHANNEL3]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_LO) +: ipr_pkg::FLD_W])
	)
	else $error("DMA 3 field misplaced");

	// Every remaining field gets its own placement check
	a_map_serial_gen:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_CRYPTO_SPI)
		|=> prio_o[ipr_pkg::SRC_SERIAL2_GENERAL]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_LO) +: ipr_pkg::FLD_W])
	)
	else $error("serial 2 general field misplaced");

	a_map_crypto_free:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_CRYPTO_SPI)
		|=> prio_o[ipr_pkg::SRC_CRYPTO_BUFFER_FREE]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_MH) +: ipr_pkg::FLD_W])
	)
	else $error("buffer free field misplaced");

	a_map_crypto_roll:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_CRYPTO_SPI)
		|=> prio_o[ipr_pkg::SRC_CRYPTO_ROLLOVER]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_HI) +: ipr_pkg::FLD_W])
	)
	else $error("rollover field misplaced");

	a_map_capture3:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_CAPTURE_DMA)
		|=> prio_o[ipr_pkg::SRC_CAPTURE3]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_ML) +: ipr_pkg::FLD_W])
	)
	else $error("capture 3 field misplaced");

	a_map_capture4:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_CAPTURE_DMA)
		|=> prio_o[ipr_pkg::SRC_CAPTURE4]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_MH) +: ipr_pkg::FLD_W])
	)
	else $error("capture 4 field misplaced");

	a_map_capture6:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_COMPARE)
		|=> prio_o[ipr_pkg::SRC_CAPTURE6]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_LO) +: ipr_pkg::FLD_W])
	)
	else $error("capture 6 field misplaced");

	a_map_compare5:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_COMPARE)
		|=> prio_o[ipr_pkg::SRC_COMPARE5]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_ML) +: ipr_pkg::FLD_W])
	)
	else $error("compare 5 field misplaced");

	a_map_timer3:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_COMPARE)
		|=> prio_o[ipr_pkg::SRC_CC_TIMER3]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_HI) +: ipr_pkg::FLD_W])
	)
	else $error("timer 3 field misplaced");

	a_map_parport:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_PARPORT)
		|=> prio_o[ipr_pkg::SRC_PARALLEL_PORT]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_ML) +: ipr_pkg::FLD_W])
	)
	else $error("parallel port field misplaced");

	a_map_dma4:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_PARPORT)
		|=> prio_o[ipr_pkg::SRC_DMA_CHANNEL4]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_MH) +: ipr_pkg::FLD_W])
	)
	else $error("DMA 4 field misplaced");

	a_map_timer5:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_PARPORT)
		|=> prio_o[ipr_pkg::SRC_CC_TIMER5]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_HI) +: ipr_pkg::FLD_W])
	)
	else $error("timer 5 field misplaced");

	a_map_timer6:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_I2C)
		|=> prio_o[ipr_pkg::SRC_CC_TIMER6]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_LO) +: ipr_pkg::FLD_W])
	)
	else $error("timer 6 field misplaced");

	a_map_i2c_slave:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_I2C)
		|=> prio_o[ipr_pkg::SRC_I2C2_SLAVE_EVENT]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_ML) +: ipr_pkg::FLD_W])
	)
	else $error("I2C2 slave field misplaced");

	a_map_timer7:
	assert property (
		(bus_i.wr && bus_i.addr == ipr_pkg::ADDR_TIMER_I2C)
		|=> prio_o[ipr_pkg::SRC_CC_TIMER7]
			== $past(bus_i.wdata[ipr_pkg::fld_lsb(ipr_pkg::SLOT_HI) +: ipr_pkg::FLD_W])
	)
	else $error("timer 7 field misplaced");

endmodule

`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the interrupt priority register bank.
// Assumes the register port answers reads one cycle after the strobe
// and that grants appear one cycle after fields and pending inputs.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	localparam int CYCLE_LIMIT = 2000;

	logic                        clk;
	logic                        arst_n;
	ipr_pkg::ipr_bus_s           bus;
	logic [ipr_pkg::SRC_NUM-1:0] pending;
	logic [ipr_pkg::DATA_W-1:0]  rdata;
	ipr_pkg::ipr_prio_vec_t      prio;
	ipr_pkg::ipr_grant_s         grant;
	int                          miscompares = 0;
	int                          checks_done = 0;
	int                          cycles = 0;
	logic [15:0]                 word;
	int                          exp_lvl;
	int                          exp_src;

	ipr_prio_regs dut
	(
		.clk_i     (clk),
		.arst_n_i  (arst_n),
		.bus_i     (bus),
		.pending_i (pending),
		.rdata_o   (rdata),
		.prio_o    (prio),
		.grant_o   (grant)
	);

	initial
	begin
		clk = 1'b0;
		forever
			#50 clk = ~clk;
	end

	// Cuts a hung run short
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == CYCLE_LIMIT)
		begin
			miscompares++;
			$display("FAIL %0t run exceeded its cycle limit", $time);
			stop_test();
		end
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic do_reset();
		arst_n <= 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
	endtask

	// Gap cycle after the strobe so no signal is assigned twice in one step
	task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
		bus.wr    <= 1'b1;
		bus.addr  <= a;
		bus.wdata <= d;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp, input string what);
		bus.rd   <= 1'b1;
		bus.addr <= a;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, exp, what);
		@(posedge clk);
	endtask

	// Write straight into a read of the same register, no idle cycle between
	task automatic wr_rd_chk(input logic [2:0] a, input logic [15:0] d, input logic [15:0] exp, input string what);
		bus.wr    <= 1'b1;
		bus.addr  <= a;
		bus.wdata <= d;
		@(posedge clk);
		bus.wr <= 1'b0;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, exp, what);
		@(posedge clk);
	endtask

	// Returns on an edge so later stimulus stays edge aligned
	task automatic grant_chk(input logic v, input int lvl, input int src, input string what);
		#1;
		chk({7'h00, grant}, {7'h00, v, 3'(lvl), 5'(src)}, what);
		@(posedge clk);
	endtask

	initial
	begin
		bus     = '0;
		pending = '0;
		arst_n  = 1'b0;
		do_reset();
		for (int r = 0; r < 5; r++)
			rd_chk(3'(r), 16'h4444, "reset word");
		for (int s = 0; s < 20; s++)
			chk(16'(prio[s]), 16'h0004, "reset field");
		$display("test reset values done");

		// Distinct field values per register, last one with bit 3 set
		for (int r = 0; r < 5; r++)
			wr_reg(3'(r), 16'h1234 + 16'(r) * 16'h1111);
		for (int r = 0; r < 5; r++)
		begin
			word = 16'h1234 + 16'(r) * 16'h1111;
			rd_chk(3'(r), word & 16'h7777, "read back");
			for (int s = 0; s < 4; s++)
				chk(16'(prio[r * 4 + s]), 16'(word[s * 4 +: 3]), "field place");
		end
		wr_rd_chk(3'h2, 16'h8a5c, 16'h0254, "write then read");
		for (int r = 0; r < 5; r++)
		begin
			wr_reg(3'(r), 16'hffff);
			rd_chk(3'(r), 16'h7777, "unimplemented bits");
		end
		for (int a = 5; a < 8; a++)
		begin
			wr_reg(3'(a), 16'h0000);
			rd_chk(3'(a), 16'h0000, "unmapped read");
		end
		for (int r = 0; r < 5; r++)
			rd_chk(3'(r), 16'h7777, "unmapped write aliased");
		$display("test register access done");

		do_reset();
		rd_chk(3'h3, 16'h4444, "second reset");
		$display("test second reset done");

		for (int r = 0; r < 5; r++)
			wr_reg(3'(r), 16'h0000);
		pending <= '1;
		@(posedge clk);
		grant_chk(1'b0, 0, 0, "all disabled");
		wr_reg(3'h1, 16'h1000);
		grant_chk(1'b1, 1, 7, "lowest level");
		wr_reg(3'h4, 16'h0070);
		grant_chk(1'b1, 7, 17, "highest level");
		wr_reg(3'h4, 16'h0000);
		wr_reg(3'h1, 16'h4000);
		pending <= 20'h00081;
		// Source 7 sits at level 4; source 0 sweeps every code
		for (int lv = 0; lv < 8; lv++)
		begin
			wr_reg(3'h0, 16'(lv));
			exp_lvl = (lv >= 4) ? lv : 4;
			exp_src = (lv >= 4) ? 0 : 7;
			grant_chk(1'b1, exp_lvl, exp_src, "level sweep");
		end
		pending <= 20'h00080;
		@(posedge clk);
		grant_chk(1'b1, 4, 7, "idle source skipped");
		$display("test arbitration done");
		stop_test();
	end
endmodule

`default_nettype wire
